// ==== sim/tb_top.sv ====
// Self-checking bench for the serial port status and control block
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {string name; logic [31:0] val; logic err; bit want;} note_s;
	logic mclk, reset, psel, penable, pwrite, pready, pslverr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata;
	logic tx_pin, tx_oe, sh_in, sh_out, sh_oe, rx_req, far_line, far_stb;
	logic tx_line;
	logic [8:0] far_got;
	logic [3:0] nbits;
	logic [31:0] seed = 32'h00003f93;
	logic [31:0] rv;
	logic [7:0] d, e_st, sent[5];
	logic [7:0] ctl[7] = '{8'h80, 8'ha0, 8'ha8, 8'hb0, 8'hb8, 8'hc1, 8'he0};
	int bad_count = 0;
	int n_checks = 0;
	note_s rd_q[$];
	note_s nt;
	logic [31:0] tx_q[$];
	// Line levels: the transmit pin floats to the pull-up when not driven; the shared pin then sees the far node
	assign sh_in = sh_oe ? sh_out : far_line;
	assign tx_line = tx_oe ? tx_pin : 1'b1;
	always #5 mclk = ~mclk;
	uart_status_ctrl dut_u (.i_mclk(mclk), .i_reset(reset), .i_psel(psel),
		.i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
		.i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
		.o_pslverr(pslverr), .o_tx_pin(tx_pin), .o_tx_pin_oe(tx_oe),
		.i_shared_pin(sh_in), .o_shared_pin(sh_out),
		.o_shared_pin_oe(sh_oe), .o_rx_request(rx_req));
	uart_far_node #(.BIT_CLKS(4)) far_u (.i_mclk(mclk), .i_line_in(tx_line),
		.i_nbits(nbits), .o_line(far_line), .o_got(far_got),
		.o_got_stb(far_stb));
	function automatic logic [7:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[7:0];
	endfunction : rnd
	// Expected line character for a control one value and data byte
	function automatic logic [31:0] frame_of(input logic [7:0] c,
		input logic [7:0] b);
		logic [8:0] v;
		logic p;
		v = {c[0] & c[6], b};
		p = c[6] ? ^v[7:0] : ^v[6:0];
		case (c[4:3])
			2'h1: p = ~p;
			2'h2: p = 1'b1;
			2'h3: p = 1'b0;
			default: p = p;
		endcase
		if (c[5])
			v[c[6] ? 8 : 7] = p;
		return {23'h0, v};
	endfunction : frame_of
	task automatic check(input string name, input logic [31:0] seen,
		input logic [31:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	task automatic finish_test();
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : finish_test
	// One APB transfer: setup, then access held until pready
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] wd, output logic [31:0] r);
		@(posedge mclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge mclk);
		penable <= 1'b1;
		do
			@(posedge mclk);
		while (pready !== 1'b1);
		r = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		apb(1'b1, a, {24'h0, v}, rv);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] e,
		input logic err, input string name);
		rd_q.push_back(note_s'{name, {24'h0, e}, err, 1'b1});
		apb(1'b0, a, 32'h0, rv);
	endtask : rd
	task automatic poll(input int b);
		logic [31:0] v;
		v = 32'h0;
		for (int n = 0; n < 300 && !v[b]; n++)
		begin
			rd_q.push_back(note_s'{"poll", 32'h0, 1'b0, 1'b0});
			apb(1'b0, uart_pkg::OFF_STATUS, 32'h0, v);
		end
	endtask : poll
	task automatic send_char(input int i, input logic [7:0] c);
		poll(uart_pkg::ST_TXIF);
		wr(uart_pkg::OFF_DATA, c);
		tx_q.push_back(frame_of(ctl[i], c));
		for (int n = 0; n < 500 && tx_q.size() > 0; n++)
			@(posedge mclk);
		// Stop bits still run after the decode; wait for the idle flag
		poll(uart_pkg::ST_TIDLE);
	endtask : send_char
	// Result watcher: oldest note is compared when a result appears
	always @(posedge mclk)
	begin
		if (psel && penable && pready === 1'b1 && !pwrite && rd_q.size() > 0)
		begin
			nt = rd_q.pop_front();
			if (nt.want)
			begin
				check(nt.name, prdata, nt.val);
				check({nt.name, " slverr"}, {31'h0, pslverr}, {31'h0, nt.err});
			end
		end
		if (far_stb === 1'b1 && tx_q.size() > 0)
			check("line frame", {23'h0, far_got}, tx_q.pop_front());
	end
	initial
	begin
		repeat (60000) @(posedge mclk);
		bad_count++;
		finish_test();
	end
	initial
	begin
		mclk = 1'b0;
		reset = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		nbits = 4'h8;
		repeat (12) @(posedge mclk);
		reset <= 1'b0;
		rd(uart_pkg::OFF_STATUS, 8'h0b, 1'b0, "status");
		rd(uart_pkg::OFF_CTRL1, 8'h00, 1'b0, "ctrl one");
		rd(8'h40, 8'h00, 1'b1, "unmapped");
		$display("reset test done");
		// Transmit at both lengths: every parity mode at eight bits, none and even at nine
		wr(uart_pkg::OFF_BAUDL, 8'h03);
		wr(uart_pkg::OFF_BAUDH, 8'h00);
		wr(uart_pkg::OFF_CTRL1, 8'h80);
		wr(uart_pkg::OFF_CTRL2, 8'hc4);
		rd(uart_pkg::OFF_STATUS, 8'h0b, 1'b0, "status");
		for (int i = 0; i < 7; i++)
		begin
			wr(uart_pkg::OFF_CTRL1, ctl[i]);
			nbits = ctl[i][6] ? 4'h9 : 4'h8;
			send_char(i, rnd());
			rd(uart_pkg::OFF_STATUS, 8'h0b, 1'b0, "status");
		end
		// Break holds the line low at least thirteen bit periods
		wr(uart_pkg::OFF_CTRL1, 8'h84);
		repeat (20) @(posedge mclk);
		check("break line", {31'h0, tx_line}, 32'h0);
		wr(uart_pkg::OFF_CTRL1, 8'h80);
		repeat (20) @(posedge mclk);
		check("break hold", {31'h0, tx_line}, 32'h0);
		repeat (20) @(posedge mclk);
		check("break end", {31'h0, tx_line}, 32'h1);
		$display("transmit test done");
		// Receive a clean, a badly framed and a wrong parity character
		wr(uart_pkg::OFF_CTRL1, 8'h80);
		nbits = 4'h8;
		// Third character carries a wrong even parity bit in slot seven
		for (int k = 0; k < 3; k++)
		begin
			d = rnd();
			if (k == 2)
			begin
				wr(uart_pkg::OFF_CTRL1, 8'ha0);
				d[7] = ~^d[6:0];
			end
			far_u.send({1'b0, d}, k != 1);
			poll(uart_pkg::ST_RXIF);
			check("rx request", {31'h0, rx_req}, 32'h1);
			e_st = (k == 1) ? 8'h2f : (k == 2) ? 8'h8f : 8'h0f;
			rd(uart_pkg::OFF_STATUS, e_st, 1'b0, "st");
			if (k == 2)
				d[7] = 1'b0;
			rd(uart_pkg::OFF_DATA, d, 1'b0, "data");
			rd(uart_pkg::OFF_STATUS, 8'h0b, 1'b0, "status");
		end
		wr(uart_pkg::OFF_CTRL1, 8'h80);
		$display("receive test done");
		// Overrun: five characters into a four entry buffer
		for (int k = 0; k < 5; k++)
		begin
			sent[k] = rnd();
			far_u.send({1'b0, sent[k]}, 1'b1);
		end
		rd(uart_pkg::OFF_STATUS, 8'h1f, 1'b0, "status");
		rd(uart_pkg::OFF_RXCOUNT, 8'h04, 1'b0, "rx count");
		for (int k = 0; k < 4; k++)
		begin
			poll(uart_pkg::ST_RXIF);
			rd(uart_pkg::OFF_DATA, sent[k], 1'b0, "data");
		end
		rd(uart_pkg::OFF_STATUS, 8'h0b, 1'b0, "status");
		$display("overrun test done");
		// Disable with a character buffered, then re-enable
		far_u.send(9'h05a, 1'b1);
		wr(uart_pkg::OFF_CTRL1, 8'h00);
		@(negedge mclk);
		check("tx drive", {31'h0, tx_oe}, 32'h0);
		rd(uart_pkg::OFF_STATUS, 8'h0b, 1'b0, "status");
		rd(uart_pkg::OFF_RXCOUNT, 8'h00, 1'b0, "rx count");
		rd(uart_pkg::OFF_CTRL2, 8'h04, 1'b0, "ctrl two");
		rd(uart_pkg::OFF_BAUDL, 8'h03, 1'b0, "baud low");
		wr(uart_pkg::OFF_CTRL1, 8'h80);
		wr(uart_pkg::OFF_CTRL2, 8'hc4);
		send_char(0, 8'h3c);
		far_u.send(9'h0c3, 1'b1);
		poll(uart_pkg::ST_RXIF);
		rd(uart_pkg::OFF_DATA, 8'hc3, 1'b0, "data");
		$display("disable test done");
		finish_test();
	end
endmodule : tb_top
`default_nettype wire

// ==== sim/uart_far_node.sv ====
// Remote serial node model: sends frames to the port and decodes its frames
`default_nettype none
module uart_far_node
#(
	parameter int BIT_CLKS = 4 // Clocks per bit period
)
(
	input wire logic i_mclk, // System clock
	input wire logic i_line_in, // Port transmit line as seen here
	input wire logic [3:0] i_nbits, // Data bits per frame
	output logic o_line, // Level driven onto the port receive line
	output logic [8:0] o_got, // Last decoded character
	output logic o_got_stb // One cycle strobe per decoded character
);
	timeunit 1ns;
	timeprecision 1ps;
	// Start, data LSB first, stop (low for a framing fault), extra stop
	task automatic send(input logic [8:0] d, input logic stop_ok);
		logic lvl;
		for (int i = 0; i < i_nbits + 3; i++)
		begin
			lvl = (i == 0) ? 1'b0 : (i <= i_nbits) ? d[i - 1] : 1'b1;
			if (i == i_nbits + 1)
				lvl = stop_ok;
			o_line <= lvl;
			repeat (BIT_CLKS) @(posedge i_mclk);
		end
	endtask : send
	// Decoder samples each bit at its centre after the falling start edge
	initial
	begin
		o_line = 1'b1;
		o_got = 9'h000;
		o_got_stb = 1'b0;
		forever
		begin
			@(posedge i_mclk);
			o_got_stb <= 1'b0;
			if (i_line_in === 1'b0)
			begin
				o_got <= 9'h000;
				repeat (BIT_CLKS / 2) @(posedge i_mclk);
				for (int i = 0; i < i_nbits; i++)
				begin
					repeat (BIT_CLKS) @(posedge i_mclk);
					o_got[i] <= i_line_in;
				end
				repeat (BIT_CLKS) @(posedge i_mclk);
				o_got_stb <= 1'b1;
			end
		end
	end
endmodule : uart_far_node
`default_nettype wire

// ==== verilog/uart_pkg.sv ====
// Constants and types shared by the serial port status and control logic
`default_nettype none
package uart_pkg;
	// Register byte offsets on the APB
	localparam logic [7:0] OFF_STATUS = 8'h00;
	localparam logic [7:0] OFF_CTRL1 = 8'h04;
	localparam logic [7:0] OFF_CTRL2 = 8'h08;
	localparam logic [7:0] OFF_CTRL3 = 8'h0c;
	localparam logic [7:0] OFF_DATA = 8'h10;
	localparam logic [7:0] OFF_BAUDH = 8'h14;
	localparam logic [7:0] OFF_BAUDL = 8'h18;
	localparam logic [7:0] OFF_FIFOCTL = 8'h1c;
	localparam logic [7:0] OFF_RXCOUNT = 8'h20;
	// Status register bit positions
	localparam int ST_PERR = 7;
	localparam int ST_NF = 6;
	localparam int ST_FERR = 5;
	localparam int ST_OERR = 4;
	localparam int ST_RIDLE = 3;
	localparam int ST_RXIF = 2;
	localparam int ST_TIDLE = 1;
	localparam int ST_TXIF = 0;
	localparam logic [7:0] STATUS_RESET = 8'h0b;
	localparam logic [7:0] ERR_MASK = 8'hf0;
	// Control register one bit positions
	localparam int CR1_EN = 7;
	localparam int CR1_BNO = 6;
	localparam int CR1_PREN = 5;
	localparam int CR1_PRT = 3;
	localparam int CR1_BRK = 2;
	localparam int CR1_RX8 = 1;
	localparam int CR1_TX8 = 0;
	localparam logic [7:0] CTRL1_RESET = 8'h00;
	// Control register two and three bit positions
	localparam int CR2_TXEN = 7;
	localparam int CR2_RXEN = 6;
	localparam int CR2_RIE = 2;
	localparam logic [7:0] CTRL2_RESET = 8'h00;
	localparam int CR3_SWM = 0;
	// Frame timing in bit periods
	localparam logic [3:0] FRAME_BITS = 4'hc;
	localparam logic [3:0] BREAK_BITS = 4'hd;
	localparam logic [3:0] DATA_BITS_8 = 4'h8;
	localparam logic [3:0] DATA_BITS_9 = 4'h9;
	// Receive buffer
	localparam logic [2:0] FIFO_DEPTH = 3'h4;
	typedef enum logic [1:0] {
		tx_idle = 2'b00,
		tx_shift = 2'b01,
		tx_break = 2'b10
	} tx_state_e;
	typedef enum logic [0:0] {
		rx_idle = 1'b0,
		rx_shift = 1'b1
	} rx_state_e;
endpackage : uart_pkg
`default_nettype wire

// ==== verilog/uart_rx_store.sv ====
// Four entry receive character store with registered read data
`default_nettype none
module uart_rx_store
(
	input wire logic i_mclk, // System clock
	input wire logic i_reset, // Async reset, active high
	input wire logic i_wr, // Write strobe
	input wire logic [1:0] i_waddr, // Write entry
	input wire logic [7:0] i_wdata, // Write character
	input wire logic [1:0] i_raddr, // Read entry
	output logic [7:0] o_rdata // Registered read character
);
	typedef struct packed {
		logic [3:0][7:0] mem;
		logic [7:0] rdata;
	} store_s;
	store_s st;
	store_s next_st;

	// Entry writes and read register
	always_comb
	begin
		next_st = st;
		next_st.rdata = st.mem[i_raddr];
		for (int k = 0; k < 4; k++)
		begin
			if (i_wr && (i_waddr == k[1:0]))
				next_st.mem[k] = i_wdata;
		end
	end

	// State register
	always_ff @(posedge i_mclk or posedge i_reset)
	begin
		if (i_reset)
			st <= '0;
		else
			st <= next_st;
	end

	assign o_rdata = st.rdata;
endmodule : uart_rx_store
`default_nettype wire

// ==== verilog/uart_status_ctrl.sv ====
// Serial port status flags, main control, APB registers and line engines
`default_nettype none
//Contract
// R1: Framing error sets its flag; status read then data access clears it.
// R2: Overrun sets its flag and blocks further receive buffer writes.
// R3: Overrun flag clears only by status read then data access; disable also clears it.
// R4: Receiver idle low from start detection to stop completion, else high.
// R5: Data available sets on transfer when trigger level met; request if enabled.
// R6: Noise, framing, parity flags set in the data available cycle.
// R7: Data available clears after armed status read, data read, buffer empty.
// R8: Transmitter idle sets when empty and nothing sent; line held high.
// R9: Transmitter idle clears by armed data write; not set while queued.
// R10: Transmit empty sets when shifter takes character; armed write clears it.
// R11: Setting transmitter enable also sets transmit empty flag.
// R12: Master enable low floats both pins; high follows mode and enables.
// R13: Disable flushes the buffer and resets the baud counters.
// R14: Disable clears enables, break, flags, count; sets idle and empty.
// R15: Disable aborts transfers; re-enable keeps the held configuration.
// R16: Length bit selects eight or nine bits; ninth bit stored separately.
// R17: With parity the last data position carries parity, not delivered.
// R18: Control one layout: enable, length, parity, type, break, ninth bits.
// R19: Status flags are read only, changed by hardware, clears, disable.
// R20: Parity type: even, odd, forced one, forced zero.
// R21: Break drives line low at least thirteen bits until cleared.
// R22: Noise flag sets with data available, never on overrun.
// R23: Status read arms clearing only of flags seen set in it.
module uart_status_ctrl
(
	input wire logic i_mclk, // System clock, 100 MHz
	input wire logic i_reset, // Async reset, active high
	input wire logic i_psel, // APB select
	input wire logic i_penable, // APB enable
	input wire logic i_pwrite, // APB direction
	input wire logic [7:0] i_paddr, // APB byte address
	input wire logic [31:0] i_pwdata, // APB write data
	output logic [31:0] o_prdata, // APB read data
	output logic o_pready, // APB ready
	output logic o_pslverr, // APB error, unmapped address
	output logic o_tx_pin, // Transmit pin level
	output logic o_tx_pin_oe, // Transmit pin drive enable
	input wire logic i_shared_pin, // Receive or shared pin level
	output logic o_shared_pin, // Shared pin level driven
	output logic o_shared_pin_oe, // Shared pin drive enable
	output logic o_rx_request // Receive data request level
);
	typedef struct packed {
		logic [7:0] cr1;
		logic [7:0] cr2;
		logic swm;
		logic [15:0] brd;
		logic [1:0] trig;
		logic [7:0] sr;
		logic [7:0] armed;
		logic [7:0] prdata;
		logic pslverr;
		logic [7:0] txd;
		logic txfull;
		uart_pkg::tx_state_e txs;
		logic [11:0] txsh;
		logic [3:0] txbits;
		logic [15:0] txcnt;
		logic txline;
		uart_pkg::rx_state_e rxs;
		logic [3:0] rxbits;
		logic [15:0] rxcnt;
		logic [8:0] rxsh;
		logic noise;
		logic early;
		logic sy1;
		logic sy2;
		logic prev;
		logic [1:0] wp;
		logic [1:0] rp;
		logic [2:0] cnt;
	} ctl_s;
	ctl_s st;
	ctl_s next_st;

	logic acc, setup, dis, push, pop, load, hit, perr_b, done, rxif_set;
	logic dwr, en, txon, rxon, bno, pren;
	logic [7:0] rdval, set, clr, rx_byte, mem_rdata;
	logic [8:0] d9, txd9;
	logic [2:0] level;
	logic [3:0] nbits;
	logic [11:0] frame;

	// Parity bit for the selected type
	function automatic logic par_bit(input logic [1:0] t,
		input logic [7:0] d);
		case (t)
			2'b00: par_bit = ^d; // R20
			2'b01: par_bit = ~^d;
			2'b10: par_bit = 1'b1;
			default: par_bit = 1'b0;
		endcase
	endfunction : par_bit

	// Next state of registers, flags and line engines
	always_comb
	begin
		next_st = st;
		set = 8'h00;
		clr = 8'h00;
		push = 1'b0;
		pop = 1'b0;
		load = 1'b0;
		dis = 1'b0;
		done = 1'b0;
		hit = 1'b1;
		rdval = 8'h00;
		acc = i_psel && i_penable;
		setup = i_psel && !i_penable;
		dwr = acc && i_pwrite && (i_paddr == uart_pkg::OFF_DATA);
		en = st.cr1[uart_pkg::CR1_EN];
		bno = st.cr1[uart_pkg::CR1_BNO];
		pren = st.cr1[uart_pkg::CR1_PREN];
		txon = en && st.cr2[uart_pkg::CR2_TXEN];
		rxon = en && st.cr2[uart_pkg::CR2_RXEN];
		nbits = bno ? uart_pkg::DATA_BITS_9 : uart_pkg::DATA_BITS_8;
		case (st.trig)
			2'b00: level = 3'h1;
			2'b01: level = 3'h2;
			default: level = uart_pkg::FIFO_DEPTH;
		endcase
		// Input synchroniser
		next_st.sy1 = i_shared_pin;
		next_st.sy2 = st.sy1;
		next_st.prev = st.sy2;
		// Read data is captured in the setup cycle
		case (i_paddr)
			uart_pkg::OFF_STATUS: rdval = st.sr; // R19
			uart_pkg::OFF_CTRL1: rdval = {st.cr1[7:1], 1'b0}; // R18
			uart_pkg::OFF_CTRL2: rdval = st.cr2;
			uart_pkg::OFF_CTRL3: rdval = {7'h00, st.swm};
			uart_pkg::OFF_DATA: rdval = mem_rdata;
			uart_pkg::OFF_BAUDH: rdval = st.brd[15:8];
			uart_pkg::OFF_BAUDL: rdval = st.brd[7:0];
			uart_pkg::OFF_FIFOCTL: rdval = {6'h00, st.trig};
			uart_pkg::OFF_RXCOUNT: rdval = {5'h00, st.cnt};
			default: hit = 1'b0;
		endcase
		if (setup)
		begin
			next_st.prdata = rdval;
			next_st.pslverr = !hit;
		end
		// Register writes in the access cycle
		if (acc && i_pwrite)
		begin
			case (i_paddr)
				uart_pkg::OFF_CTRL1:
				begin
					next_st.cr1 = {i_pwdata[7:2], st.cr1[uart_pkg::CR1_RX8],
						i_pwdata[0]}; // R18
					dis = en && !i_pwdata[uart_pkg::CR1_EN];
				end
				uart_pkg::OFF_CTRL2:
				begin
					next_st.cr2 = i_pwdata[7:0];
					if (!st.cr2[uart_pkg::CR2_TXEN] && i_pwdata[uart_pkg::CR2_TXEN])
						set[uart_pkg::ST_TXIF] = 1'b1; // R11
				end
				uart_pkg::OFF_CTRL3: next_st.swm = i_pwdata[uart_pkg::CR3_SWM];
				uart_pkg::OFF_BAUDH: next_st.brd[15:8] = i_pwdata[7:0];
				uart_pkg::OFF_BAUDL: next_st.brd[7:0] = i_pwdata[7:0];
				uart_pkg::OFF_FIFOCTL: next_st.trig = i_pwdata[1:0];
				uart_pkg::OFF_DATA:
				begin
					next_st.txd = i_pwdata[7:0];
					next_st.txfull = 1'b1;
				end
				default: ;
			endcase
		end
		// Status read arms the clear with the flags it returned
		if (acc && !i_pwrite && i_paddr == uart_pkg::OFF_STATUS)
			next_st.armed = st.prdata; // R23
		// Data access clears armed flags
		if (acc && i_paddr == uart_pkg::OFF_DATA)
		begin
			clr = st.armed & uart_pkg::ERR_MASK; // R1 R3
			if (i_pwrite)
			begin
				clr[uart_pkg::ST_TXIF] = st.armed[uart_pkg::ST_TXIF]; // R10
				clr[uart_pkg::ST_TIDLE] = st.armed[uart_pkg::ST_TIDLE]; // R9
			end
			else
			begin
				pop = (st.cnt != 3'h0);
				if (st.cnt <= 3'h1)
					clr[uart_pkg::ST_RXIF] = st.armed[uart_pkg::ST_RXIF]; // R7
			end
			next_st.armed = 8'h00;
		end
		// Transmit frame with optional parity in the last data slot
		txd9 = {st.cr1[uart_pkg::CR1_TX8], st.txd}; // R16
		if (pren && bno)
			txd9[8] = par_bit(st.cr1[uart_pkg::CR1_PRT +: 2], txd9[7:0]); // R17
		else if (pren)
			txd9[7] = par_bit(st.cr1[uart_pkg::CR1_PRT +: 2],
				{1'b0, txd9[6:0]}); // R17
		frame = bno ? {2'b11, txd9, 1'b0} : {3'b111, txd9[7:0], 1'b0};
		// Transmit engine
		if (!txon)
		begin
			next_st.txs = uart_pkg::tx_idle;
			next_st.txline = 1'b1;
		end
		else
		begin
			if (st.txcnt != 16'h0000)
				next_st.txcnt = st.txcnt - 16'h0001;
			case (st.txs)
				uart_pkg::tx_idle:
				begin
					next_st.txline = 1'b1; // R8
					next_st.txcnt = st.brd;
					next_st.txbits = 4'h1;
					if (st.txfull)
					begin
						load = 1'b1;
						next_st.txfull = dwr;
						set[uart_pkg::ST_TXIF] = 1'b1; // R10
						next_st.txsh = frame;
						next_st.txline = frame[0];
						next_st.txs = uart_pkg::tx_shift;
					end
					else if (st.cr1[uart_pkg::CR1_BRK])
					begin
						next_st.txline = 1'b0; // R21
						next_st.txs = uart_pkg::tx_break;
					end
				end
				uart_pkg::tx_shift:
				begin
					if (st.txcnt == 16'h0000)
					begin
						next_st.txcnt = st.brd;
						if (st.txbits == uart_pkg::FRAME_BITS)
						begin
							next_st.txline = 1'b1;
							next_st.txs = uart_pkg::tx_idle;
						end
						else
						begin
							next_st.txline = st.txsh[1];
							next_st.txsh = {1'b1, st.txsh[11:1]};
							next_st.txbits = st.txbits + 4'h1;
						end
					end
				end
				uart_pkg::tx_break:
				begin
					next_st.txline = 1'b0; // R21
					if (st.txcnt == 16'h0000)
					begin
						next_st.txcnt = st.brd;
						if (st.txbits != uart_pkg::BREAK_BITS)
							next_st.txbits = st.txbits + 4'h1;
						else if (!st.cr1[uart_pkg::CR1_BRK])
						begin
							next_st.txline = 1'b1;
							next_st.txs = uart_pkg::tx_idle;
						end
					end
				end
				default: next_st.txs = uart_pkg::tx_idle;
			endcase
		end
		// Transmitter idle when empty, nothing queued and nothing sent
		if (en && st.txs == uart_pkg::tx_idle && !st.txfull && !dwr &&
			st.sr[uart_pkg::ST_TXIF] && !st.cr1[uart_pkg::CR1_BRK])
			set[uart_pkg::ST_TIDLE] = 1'b1; // R8 R9
		// Receive engine, sampled at mid bit
		d9 = bno ? st.rxsh : {1'b0, st.rxsh[8:1]};
		perr_b = pren && ((bno ? d9[8] : d9[7]) !=
			par_bit(st.cr1[uart_pkg::CR1_PRT +: 2],
			bno ? d9[7:0] : {1'b0, d9[6:0]})); // R20
		rx_byte = (pren && !bno) ? {1'b0, d9[6:0]} : d9[7:0]; // R17
		if (!rxon)
		begin
			next_st.rxs = uart_pkg::rx_idle;
			set[uart_pkg::ST_RIDLE] = 1'b1;
		end
		else
		begin
			if (st.rxcnt != 16'h0000)
				next_st.rxcnt = st.rxcnt - 16'h0001;
			if (st.rxcnt == 16'h0001)
				next_st.early = st.sy2;
			case (st.rxs)
				uart_pkg::rx_idle:
				begin
					if (st.prev && !st.sy2)
					begin
						next_st.rxs = uart_pkg::rx_shift;
						next_st.rxcnt = {1'b0, st.brd[15:1]};
						next_st.rxbits = 4'h0;
						next_st.noise = 1'b0;
						clr[uart_pkg::ST_RIDLE] = 1'b1; // R4
					end
				end
				uart_pkg::rx_shift:
				begin
					if (st.rxcnt == 16'h0000)
					begin
						next_st.rxcnt = st.brd;
						next_st.rxbits = st.rxbits + 4'h1;
						if (st.brd != 16'h0000 && st.early != st.sy2)
							next_st.noise = 1'b1;
						if (st.rxbits == 4'h0 && st.sy2)
						begin
							next_st.rxs = uart_pkg::rx_idle;
							set[uart_pkg::ST_RIDLE] = 1'b1;
						end
						else if (st.rxbits != 4'h0 && st.rxbits <= nbits)
							next_st.rxsh = {st.sy2, st.rxsh[8:1]};
						else if (st.rxbits != 4'h0)
						begin
							done = 1'b1;
							next_st.rxs = uart_pkg::rx_idle;
							set[uart_pkg::ST_RIDLE] = 1'b1; // R4
						end
					end
				end
				default: next_st.rxs = uart_pkg::rx_idle;
			endcase
		end
		// Character transfer into the receive buffer
		rxif_set = 1'b0;
		if (done)
		begin
			if (st.sr[uart_pkg::ST_OERR] || st.cnt == uart_pkg::FIFO_DEPTH)
				set[uart_pkg::ST_OERR] = 1'b1; // R2 R22
			else
			begin
				push = 1'b1;
				rxif_set = (st.cnt + 3'h1 - {2'b00, pop}) >= level;
				set[uart_pkg::ST_RXIF] = rxif_set; // R5
				set[uart_pkg::ST_PERR] = perr_b; // R6
				set[uart_pkg::ST_FERR] = !st.sy2; // R1 R6
				set[uart_pkg::ST_NF] = next_st.noise; // R22
				if (bno && !pren)
					next_st.cr1[uart_pkg::CR1_RX8] = d9[8]; // R16
			end
		end
		if (push)
			next_st.wp = st.wp + 2'h1;
		if (pop)
			next_st.rp = st.rp + 2'h1;
		next_st.cnt = st.cnt + {2'b00, push} - {2'b00, pop};
		// Flags change only by events, clears and disable; set wins
		next_st.sr = (st.sr & ~clr) | set; // R19
		// Disable aborts transfers and flushes, keeping configuration
		if (dis)
		begin
			next_st.cr2[uart_pkg::CR2_TXEN] = 1'b0; // R14
			next_st.cr2[uart_pkg::CR2_RXEN] = 1'b0;
			next_st.cr1[uart_pkg::CR1_BRK] = 1'b0;
			next_st.sr = uart_pkg::STATUS_RESET;
			next_st.cnt = 3'h0; // R13
			next_st.wp = 2'h0;
			next_st.rp = 2'h0;
			next_st.txfull = 1'b0;
			next_st.txcnt = 16'h0000;
			next_st.rxcnt = 16'h0000;
			next_st.txs = uart_pkg::tx_idle; // R15
			next_st.rxs = uart_pkg::rx_idle;
			next_st.txline = 1'b1;
		end
	end

	// State register
	always_ff @(posedge i_mclk or posedge i_reset)
	begin
		if (i_reset)
		begin
			st <= '0;
			st.cr1 <= uart_pkg::CTRL1_RESET;
			st.cr2 <= uart_pkg::CTRL2_RESET;
			st.sr <= uart_pkg::STATUS_RESET;
			st.txline <= 1'b1;
			st.sy1 <= 1'b1;
			st.sy2 <= 1'b1;
			st.prev <= 1'b1;
		end
		else
			st <= next_st;
	end

	// Receive buffer storage
	uart_rx_store u_store
	(
		.i_mclk(i_mclk),
		.i_reset(i_reset),
		.i_wr(push),
		.i_waddr(st.wp),
		.i_wdata(rx_byte),
		.i_raddr(st.rp),
		.o_rdata(mem_rdata)
	);

	// Outputs; pins float while the port is disabled
	assign o_prdata = {24'h000000, st.prdata};
	assign o_pready = 1'b1;
	assign o_pslverr = st.pslverr;
	assign o_tx_pin = st.txline;
	assign o_tx_pin_oe = txon; // R12
	assign o_shared_pin = st.txline;
	assign o_shared_pin_oe = txon && st.swm &&
		!st.cr2[uart_pkg::CR2_RXEN]; // R12
	assign o_rx_request = st.sr[uart_pkg::ST_RXIF] &&
		st.cr2[uart_pkg::CR2_RIE]; // R5

	default clocking cb @(posedge i_mclk);
	endclocking
	default disable iff (i_reset);

	AST_FERR_SET: assert property (push && !st.sy2 && !dis |=> // R1
		st.sr[uart_pkg::ST_FERR]) else $error("framing flag not set");
	AST_OERR_BLOCK: assert property (st.sr[uart_pkg::ST_OERR] |-> // R2
		!push) else $error("write while overrun");
	AST_OERR_HOLD: assert property (st.sr[uart_pkg::ST_OERR] && // R3
		!(acc && i_paddr == uart_pkg::OFF_DATA) && !dis |=>
		st.sr[uart_pkg::ST_OERR]) else $error("overrun lost");
	AST_RIDLE: assert property (st.sr[uart_pkg::ST_RIDLE] == // R4
		(st.rxs == uart_pkg::rx_idle)) else $error("idle mismatch");
	AST_ERR_WITH_RXIF: assert property (push && rxif_set && perr_b && // R6
		!dis |=> st.sr[uart_pkg::ST_RXIF] && st.sr[uart_pkg::ST_PERR])
		else $error("errors not with data flag");
	AST_RXIF_KEEP: assert property (st.sr[uart_pkg::ST_RXIF] && // R7
		st.cnt > 3'h1 && !dis |=> st.sr[uart_pkg::ST_RXIF])
		else $error("data flag cleared early");
	AST_TX_IDLE_HIGH: assert property (st.txs == uart_pkg::tx_idle |-> // R8
		o_tx_pin) else $error("idle line not high");
	AST_TXIF_LOAD: assert property (load && !dis |=> // R10
		st.sr[uart_pkg::ST_TXIF] && st.txs == uart_pkg::tx_shift)
		else $error("empty flag not set on load");
	AST_TXEN_TXIF: assert property (acc && i_pwrite && !dis && // R11
		i_paddr == uart_pkg::OFF_CTRL2 && i_pwdata[uart_pkg::CR2_TXEN] &&
		!st.cr2[uart_pkg::CR2_TXEN] |=> st.sr[uart_pkg::ST_TXIF])
		else $error("enable did not set empty flag");
	AST_FLOAT: assert property (!en |-> !o_tx_pin_oe && // R12
		!o_shared_pin_oe) else $error("pin driven while disabled");
	AST_DISABLE: assert property (dis |=> st.sr == // R14
		uart_pkg::STATUS_RESET && st.cnt == 3'h0 &&
		!st.cr2[uart_pkg::CR2_TXEN]) else $error("disable state wrong");
	AST_BREAK_LOW: assert property (st.txs == uart_pkg::tx_break // R21
		&& st.txbits != uart_pkg::BREAK_BITS && txon && !dis |=>
		!o_tx_pin) else $error("break released early");
	AST_NF_NO_OVR: assert property (done && !push |=> // R22
		!$rose(st.sr[uart_pkg::ST_NF])) else $error("noise on overrun");

	COV_PUSH: cover property (push);
	COV_LOAD: cover property (load);
	COV_OVR: cover property ($rose(st.sr[uart_pkg::ST_OERR]));
	COV_BREAK: cover property (st.txs == uart_pkg::tx_break);
endmodule : uart_status_ctrl
`default_nettype wire
